// File: hdl/rcc_div.sv
// glitch-free tick divider used for the clock paths
`timescale 1ns/1ps
module rcc_div
  import rcc_pkg::*;
#(
  parameter int W = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run, // low holds the divider idle
  input wire logic tick_in, // source tick
  input wire logic [W-1:0] div, // terminal count, divides by div+1
  output logic tick_out // one tick per div+1 source ticks
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] cnt; // source ticks seen in this period
    logic [W-1:0] lim; // terminal count latched for this period
    logic tick; // registered output tick
  } rcc_div_st_t;
  rcc_div_st_t s_r;
  rcc_div_st_t s_nxt;
  // next state: new divide value taken only at a period boundary or while idle
  always_comb begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    if (!run) begin
      s_nxt.cnt = '0;
      s_nxt.lim = div;
    end else if (tick_in) begin
      if (s_r.cnt == s_r.lim) begin
        s_nxt.cnt = '0;
        s_nxt.lim = div;
        s_nxt.tick = 1'b1;
      end else begin
        s_nxt.cnt = s_r.cnt + 1'b1;
      end
    end
  end
  // register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign tick_out = s_r.tick;
endmodule

// File: hdl/rcc_lock.sv
// pll lock delay timer, restarts whenever the pll is powered down
`timescale 1ns/1ps
module rcc_lock
  import rcc_pkg::*;
#(
  parameter int CYC = PLL_LOCK_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pll_on, // pll powered and running
  output logic locked // high once the lock delay has elapsed
);
  localparam int CW = $clog2(CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(CYC - 1);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [CW-1:0] cnt; // cycles since power up
    logic locked; // delay elapsed
  } rcc_lock_st_t;
  rcc_lock_st_t s_r;
  rcc_lock_st_t s_nxt;
  // count the delay; any power down throws the lock away
  always_comb begin
    s_nxt = s_r;
    if (!pll_on) begin
      s_nxt.cnt = '0;
      s_nxt.locked = 1'b0;
    end else if (!s_r.locked) begin
      if (s_r.cnt == LAST) begin
        s_nxt.locked = 1'b1;
      end else begin
        s_nxt.cnt = s_r.cnt + 1'b1;
      end
    end
  end
  // register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign locked = s_r.locked;
endmodule

// File: hdl/rcc_pkg.sv
// constants, register map and state codes of the reset and clock control block
// Notes on behaviour
// - relock delay after low power wake before multiplied clock
// - wait without low power stops core only
// - divide-by-16 select feeds halved oscillator /16
// - pll divider divides by field plus one
// - core prescaler divides internal clock by value+1
// - external reset clears both cause flags
// - watchdog reset sets watchdog flag only
// - enabled halt gives software reset, waits
// - cause flags read-only, updated each reset
// - divider field all ones switches pll off
package rcc_pkg;
  // ---------------------------------------------------------------
  // bus geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_CLOCK_CONTROL = 8'h00; // clock_control_reg
  localparam logic [ADDR_W-1:0] OFF_CLOCK_SOURCE = 8'h04; // clock_source_select_reg
  localparam logic [ADDR_W-1:0] OFF_PLL_CONFIG = 8'h08; // pll_config_reg
  localparam logic [ADDR_W-1:0] OFF_CORE_PRESC = 8'h0c; // core prescaler
  localparam logic [ADDR_W-1:0] OFF_RESET_FLAGS = 8'h10; // read-only cause flags
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h14; // sticky events, read-only
  localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 8'h18; // event enables
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR = 8'h1c; // write one to clear
  // ---------------------------------------------------------------
  // field positions and widths
  // ---------------------------------------------------------------
  localparam int BIT_LOW_POWER_ON_WAIT = 0;
  localparam int BIT_HALT_RESET_ENABLE = 1;
  localparam int BIT_OSC_DIV16_SELECT = 0;
  localparam int BIT_SOFTWARE_FLAG = 0;
  localparam int BIT_WATCHDOG_FLAG = 1;
  localparam int BIT_PLL_LOCKED = 2;
  localparam int DIV_W = 3;
  localparam int EV_W = 3;
  localparam int EV_PLL_LOCK = 0;
  localparam int EV_WAKE = 1;
  localparam int EV_RESET_CAUSE = 2;
  // ---------------------------------------------------------------
  // reset values and divider codes
  // ---------------------------------------------------------------
  localparam logic [DIV_W-1:0] PLL_DIV_OFF = 3'h7; // all ones: pll powered down
  localparam logic [DIV_W-1:0] PLL_DIV_RESET = 3'h7;
  localparam logic [DIV_W-1:0] PRESC_RESET = 3'h0;
  localparam int OSC16_W = 4;
  localparam logic [OSC16_W-1:0] OSC16_DIV = 4'hf; // terminal count 15 gives /16
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int PLL_LOCK_NS = 10000; // plain default lock time
  localparam int PLL_LOCK_CYC = (PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ---------------------------------------------------------------
  // enumerations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN = 2'b00, // core and internal clocks running
    ST_CORE_STOP = 2'b01, // wait, core clock stopped, internal unchanged
    ST_PLL_FROZEN = 2'b10, // low power wait, pll frozen
    ST_HALTED = 2'b11 // software reset, waiting for external reset
  } rcc_state_t;
  typedef enum logic [1:0] {
    SRC_HALF = 2'b00, // halved oscillator clock
    SRC_DIV16 = 2'b01, // halved oscillator clock / 16
    SRC_PLL = 2'b10 // pll output through its divider
  } rcc_src_t;
endpackage

// File: hdl/rcc_top.sv
// reset cause flags and low-power clock paths with an axi4-lite register slave
`timescale 1ns/1ps
module rcc_top
  import rcc_pkg::*;
#(
  parameter int LOCK_CYC = PLL_LOCK_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_reset_pin_n, // external reset pin level
  input wire logic watchdog_zero, // pulse: active watchdog reached zero
  input wire logic halt_exec, // pulse: core executes halt
  input wire logic wait_for_interrupt, // pulse: core executes wait
  input wire logic wake_irq, // pulse: interrupt ends a wait
  output logic internal_clock_tick, // one-cycle tick of internal_clock
  output logic core_clock_tick, // one-cycle tick of core_clock
  output logic pll_enable, // pll power
  output logic sys_reset_req, // one-cycle pulse: reset the rest of the chip
  output logic core_halted, // high while waiting for external reset
  output logic irq // level interrupt
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic aw_have; // write address held
    logic [ADDR_W-1:0] aw_addr;
    logic w_have; // write data held
    logic [DATA_W-1:0] w_data;
    logic [3:0] w_strb;
    logic aw_rdy;
    logic w_rdy;
    logic b_valid;
    logic [1:0] b_resp;
    logic ar_rdy;
    logic r_valid;
    logic [DATA_W-1:0] r_data;
    logic [1:0] r_resp;
    logic low_power_on_wait; // wait freezes the pll when set
    logic halt_reset_enable; // halt becomes a software reset
    logic osc_div16_select; // internal clock from half osc / 16
    logic [DIV_W-1:0] pll_out_divider;
    logic [DIV_W-1:0] core_presc;
    logic software_reset_flag;
    logic watchdog_reset_flag;
    logic [EV_W-1:0] irq_status;
    logic [EV_W-1:0] irq_enable;
    logic irq;
    rcc_state_t state;
    rcc_src_t src; // source currently driving internal_clock
    logic pin_prev; // last external pin level, for the falling edge
    logic half_phase; // halved oscillator clock phase
    logic locked_prev;
    logic int_tick;
    logic core_tick;
    logic pll_en;
    logic sys_reset;
    logic halted; // flop behind core_halted
  } rcc_st_t;
  rcc_st_t s_r;
  rcc_st_t s_nxt;
  // ---------------------------------------------------------------
  // clock path wiring
  // ---------------------------------------------------------------
  logic half_tick; // halved oscillator tick, every second cycle
  logic div16_tick; // half osc divided by 16
  logic pll_tick; // pll output after its divider
  logic presc_tick; // internal clock after the core prescaler
  logic pll_locked; // lock delay elapsed
  logic pll_run; // pll divider may run
  logic src_tick; // tick of the currently selected source
  assign half_tick = s_r.half_phase;
  assign pll_run = s_r.pll_en && pll_locked;
  // half osc / 16 path, no pll needed
  rcc_div #(.W(OSC16_W)) u_div16 (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(s_r.osc_div16_select),
    .tick_in(half_tick),
    .div(OSC16_DIV),
    .tick_out(div16_tick)
  );
  // pll output divider; the multiplied clock is modelled as one tick per cycle
  rcc_div #(.W(DIV_W)) u_pll_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(pll_run),
    .tick_in(1'b1),
    .div(s_r.pll_out_divider),
    .tick_out(pll_tick)
  );
  // core prescaler driven from the internal clock
  rcc_div #(.W(DIV_W)) u_presc (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(1'b1),
    .tick_in(s_r.int_tick),
    .div(s_r.core_presc),
    .tick_out(presc_tick)
  );
  // lock delay
  rcc_lock #(.CYC(LOCK_CYC)) u_lock (
    .aclk(aclk),
    .aresetn(aresetn),
    .pll_on(s_r.pll_en),
    .locked(pll_locked)
  );
  // tick of the active source
  always_comb begin
    case (s_r.src)
      SRC_DIV16: src_tick = div16_tick;
      SRC_PLL: src_tick = pll_tick;
      default: src_tick = half_tick;
    endcase
  end
  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic aw_go;
    logic w_go;
    logic wr_do;
    logic ext_fall;
    logic [EV_W-1:0] ev;
    logic [EV_W-1:0] clr;
    logic [DATA_W-1:0] rd;
    logic rd_ok;
    logic wr_ok;
    rcc_src_t want;
    aw_go = 1'b0;
    w_go = 1'b0;
    wr_do = 1'b0;
    ext_fall = 1'b0;
    ev = '0;
    clr = '0;
    rd = '0;
    rd_ok = 1'b1;
    wr_ok = 1'b1;
    want = SRC_HALF;
    s_nxt = s_r;
    s_nxt.sys_reset = 1'b0;
    s_nxt.half_phase = ~s_r.half_phase;
    s_nxt.pin_prev = ext_reset_pin_n;
    s_nxt.locked_prev = pll_locked;
    // write channels, taken in either order
    aw_go = s_axi_awvalid && s_r.aw_rdy;
    w_go = s_axi_wvalid && s_r.w_rdy;
    if (aw_go) begin
      s_nxt.aw_have = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (w_go) begin
      s_nxt.w_have = 1'b1;
      s_nxt.w_data = s_axi_wdata;
      s_nxt.w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      s_nxt.b_valid = 1'b0;
    end
    // write completes once both halves are held and no response is pending
    wr_do = s_r.aw_have && s_r.w_have && !s_r.b_valid;
    if (wr_do) begin
      s_nxt.aw_have = 1'b0;
      s_nxt.w_have = 1'b0;
      s_nxt.b_valid = 1'b1;
      if (s_r.w_strb[0]) begin
        case (s_r.aw_addr)
          OFF_CLOCK_CONTROL: begin
            s_nxt.low_power_on_wait = s_r.w_data[BIT_LOW_POWER_ON_WAIT];
            s_nxt.halt_reset_enable = s_r.w_data[BIT_HALT_RESET_ENABLE];
          end
          OFF_CLOCK_SOURCE: s_nxt.osc_div16_select = s_r.w_data[BIT_OSC_DIV16_SELECT];
          OFF_PLL_CONFIG: s_nxt.pll_out_divider = s_r.w_data[DIV_W-1:0];
          OFF_CORE_PRESC: s_nxt.core_presc = s_r.w_data[DIV_W-1:0];
          OFF_IRQ_ENABLE: s_nxt.irq_enable = s_r.w_data[EV_W-1:0];
          OFF_IRQ_CLEAR: clr = s_r.w_data[EV_W-1:0];
          OFF_RESET_FLAGS: wr_ok = 1'b1;
          OFF_IRQ_STATUS: wr_ok = 1'b1;
          default: wr_ok = 1'b0;
        endcase
      end else begin
        // strobes outside the low byte leave every field alone
        wr_ok = (s_r.aw_addr <= OFF_IRQ_CLEAR) && (s_r.aw_addr[1:0] == 2'h0);
      end
      s_nxt.b_resp = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    // one outstanding write: ready drops while a half is held or answered
    s_nxt.aw_rdy = !s_nxt.aw_have && !s_nxt.b_valid;
    s_nxt.w_rdy = !s_nxt.w_have && !s_nxt.b_valid;
    // read channel
    if (s_axi_rvalid && s_axi_rready) begin
      s_nxt.r_valid = 1'b0;
    end
    if (s_axi_arvalid && s_r.ar_rdy) begin
      case (s_axi_araddr)
        OFF_CLOCK_CONTROL: begin
          rd[BIT_LOW_POWER_ON_WAIT] = s_r.low_power_on_wait;
          rd[BIT_HALT_RESET_ENABLE] = s_r.halt_reset_enable;
        end
        OFF_CLOCK_SOURCE: rd[BIT_OSC_DIV16_SELECT] = s_r.osc_div16_select;
        OFF_PLL_CONFIG: rd[DIV_W-1:0] = s_r.pll_out_divider;
        OFF_CORE_PRESC: rd[DIV_W-1:0] = s_r.core_presc;
        OFF_RESET_FLAGS: begin
          rd[BIT_SOFTWARE_FLAG] = s_r.software_reset_flag;
          rd[BIT_WATCHDOG_FLAG] = s_r.watchdog_reset_flag;
          rd[BIT_PLL_LOCKED] = pll_locked;
        end
        OFF_IRQ_STATUS: rd[EV_W-1:0] = s_r.irq_status;
        OFF_IRQ_ENABLE: rd[EV_W-1:0] = s_r.irq_enable;
        OFF_IRQ_CLEAR: rd = '0; // write-only, reads as zero
        default: rd_ok = 1'b0;
      endcase
      s_nxt.r_valid = 1'b1;
      s_nxt.r_data = rd;
      s_nxt.r_resp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    s_nxt.ar_rdy = !s_nxt.r_valid;
    // reset causes; the external pin is checked first so it wins
    ext_fall = s_r.pin_prev && !ext_reset_pin_n;
    if (ext_fall) begin
      s_nxt.software_reset_flag = 1'b0;
      s_nxt.watchdog_reset_flag = 1'b0;
      s_nxt.state = ST_RUN;
      s_nxt.sys_reset = 1'b1;
      ev[EV_RESET_CAUSE] = 1'b1;
    end else if (watchdog_zero) begin
      s_nxt.software_reset_flag = 1'b0;
      s_nxt.watchdog_reset_flag = 1'b1;
      s_nxt.state = ST_RUN;
      s_nxt.sys_reset = 1'b1;
      ev[EV_RESET_CAUSE] = 1'b1;
    end else if (halt_exec && s_r.halt_reset_enable && s_r.state != ST_HALTED) begin
      // the chip stays halted until the pin or a watchdog reset restarts it
      s_nxt.software_reset_flag = 1'b1;
      s_nxt.watchdog_reset_flag = 1'b0;
      s_nxt.state = ST_HALTED;
      s_nxt.sys_reset = 1'b1;
      ev[EV_RESET_CAUSE] = 1'b1;
    end else begin
      // wait and wake sequencing
      case (s_r.state)
        ST_RUN: begin
          if (wait_for_interrupt) begin
            // low power wait freezes the pll; otherwise only the core stops
            s_nxt.state = s_r.low_power_on_wait ? ST_PLL_FROZEN : ST_CORE_STOP;
          end
        end
        ST_CORE_STOP, ST_PLL_FROZEN: begin
          if (wake_irq) begin
            s_nxt.state = ST_RUN;
            ev[EV_WAKE] = 1'b1;
          end
        end
        ST_HALTED: s_nxt.state = ST_HALTED;
        default: s_nxt.state = ST_RUN;
      endcase
    end
    s_nxt.halted = (s_nxt.state == ST_HALTED);
    // pll power: off for the all-ones divider, while frozen and while halted
    s_nxt.pll_en = (s_nxt.pll_out_divider != PLL_DIV_OFF)
      && (s_nxt.state != ST_PLL_FROZEN) && (s_nxt.state != ST_HALTED);
    // requested source; the pll is used only once the lock delay is over
    if (s_r.osc_div16_select) begin
      want = SRC_DIV16;
    end else if (pll_run) begin
      want = SRC_PLL;
    end else begin
      want = SRC_HALF;
    end
    // switch only at the end of a period of the old source, so no short pulse;
    // a pll that stopped or a deselected /16 divider gives no ticks, so leaving it at once is safe
    if (want != s_r.src) begin
      if (src_tick || (s_r.src == SRC_PLL && !pll_run)
          || (s_r.src == SRC_DIV16 && !s_r.osc_div16_select)) begin
        s_nxt.src = want;
      end
    end
    // internal clock keeps running through a plain wait
    s_nxt.int_tick = src_tick && (s_r.state != ST_HALTED);
    // core clock only while running
    s_nxt.core_tick = presc_tick && (s_r.state == ST_RUN);
    // interrupt events; a set in the clearing cycle survives
    ev[EV_PLL_LOCK] = pll_locked && !s_r.locked_prev;
    s_nxt.irq_status = (s_r.irq_status & ~clr) | ev;
    s_nxt.irq = |(s_nxt.irq_status & s_nxt.irq_enable);
  end
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // power-on reset counts as an external reset: both flags zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.aw_rdy <= 1'b1;
      s_r.w_rdy <= 1'b1;
      s_r.ar_rdy <= 1'b1;
      s_r.pll_out_divider <= PLL_DIV_RESET;
      s_r.core_presc <= PRESC_RESET;
      s_r.state <= ST_RUN;
      s_r.src <= SRC_HALF;
      s_r.pin_prev <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end
  // ---------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ---------------------------------------------------------------
  assign s_axi_awready = s_r.aw_rdy;
  assign s_axi_wready = s_r.w_rdy;
  assign s_axi_bvalid = s_r.b_valid;
  assign s_axi_bresp = s_r.b_resp;
  assign s_axi_arready = s_r.ar_rdy;
  assign s_axi_rvalid = s_r.r_valid;
  assign s_axi_rdata = s_r.r_data;
  assign s_axi_rresp = s_r.r_resp;
  assign internal_clock_tick = s_r.int_tick;
  assign core_clock_tick = s_r.core_tick;
  assign pll_enable = s_r.pll_en;
  assign sys_reset_req = s_r.sys_reset;
  assign core_halted = s_r.halted;
  assign irq = s_r.irq;
endmodule

// File: tb/rcc_checker.sv
// concurrent checks on the reset and clock control top
`timescale 1ns/1ps
module rcc_checker
  import rcc_pkg::*;
#(
  parameter int LOCK_CYC = PLL_LOCK_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic ext_reset_pin_n,
  input wire logic watchdog_zero,
  input wire logic halt_exec,
  input wire logic wait_for_interrupt,
  input wire logic wake_irq,
  input wire logic internal_clock_tick,
  input wire logic core_clock_tick,
  input wire logic pll_enable,
  input wire logic sys_reset_req,
  input wire logic core_halted
);
  // ----
  // helper counters
  // ----
  int gap_r; // cycles since last internal tick
  int on_r; // cycles of unbroken pll power
  // a halted core may stop all clocks, so the gap restarts there
  always_ff @(posedge aclk) begin
    gap_r <= (!aresetn || internal_clock_tick || core_halted) ? 0 : gap_r + 1;
    on_r <= (!aresetn || !pll_enable) ? 0 : on_r + 1;
  end
  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----
  // properties
  // ----
  sequence s_wait_req;
    wait_for_interrupt && !core_halted && !wake_irq && ext_reset_pin_n;
  endsequence
  sequence s_core_quiet;
    !core_clock_tick [*4];
  endsequence
  property p_wait_stops; s_wait_req |-> ##4 s_core_quiet; endproperty
  a_wait_stops: assert property (p_wait_stops) else $error("core tick in wait");
  property p_gap; gap_r < 40; endproperty
  a_gap: assert property (p_gap) else $error("internal clock gap");
  // slack of two covers the registered tick path
  property p_lock; internal_clock_tick && $past(internal_clock_tick) |-> $past(on_r, 2) >= LOCK_CYC - 2; endproperty
  a_lock: assert property (p_lock) else $error("pll used before lock");
  property p_ext; $fell(ext_reset_pin_n) |=> sys_reset_req && !core_halted; endproperty
  a_ext: assert property (p_ext) else $error("pin reset lost");
  property p_halt_in; $rose(core_halted) |-> $past(halt_exec) && sys_reset_req; endproperty
  a_halt_in: assert property (p_halt_in) else $error("halt without cause");
  property p_halt_hold; core_halted && !$fell(ext_reset_pin_n) |=> core_halted; endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("halt left early");
  property p_wdog; watchdog_zero && !core_halted |=> sys_reset_req; endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog reset lost");
  property p_b; $rose(s_axi_bvalid) |-> !s_axi_awready && !s_axi_wready; endproperty
  a_b: assert property (p_b) else $error("write overlap");
  property p_r; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_r: assert property (p_r) else $error("read answer late");
endmodule

// File: tb/rcc_core_model.sv
// core model issuing halt, wait and wake pulses
`timescale 1ns/1ps
module rcc_core_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [2:0] op, // 1 halt, 2 wait, 3 wake
  output logic halt_exec = 1'b0,
  output logic wait_for_interrupt = 1'b0,
  output logic wake_irq = 1'b0
);
  // ----
  // instruction pulses
  // ----
  // registered so every pulse leaves just after an edge
  always @(posedge aclk) begin
    halt_exec <= aresetn && op == 3'h1;
    wait_for_interrupt <= aresetn && op == 3'h2;
    wake_irq <= aresetn && op == 3'h3;
  end
endmodule

// File: tb/test_rcc_top.sv
// self-checking bench for the reset and clock control top
`timescale 1ns/1ps
module test_rcc_top;
  import rcc_pkg::*;
  // ----
  // signals
  // ----
  localparam int LOCK = 16; // short lock keeps the run brief
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_bready = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d, n;
  logic ext_reset_pin_n = 1'b1, watchdog_zero = 1'b0;
  logic [2:0] op = 3'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic halt_exec, wait_for_interrupt, wake_irq, internal_clock_tick, core_clock_tick;
  logic pll_enable, sys_reset_req, core_halted;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  int errors = 0, checked = 0, cyc = 0;
  logic [7:0] ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h18};
  logic [31:0] rv [6] = '{32'h0, 32'h0, 32'h7, 32'h0, 32'h0, 32'h0};
  initial forever #25 aclk = ~aclk;
  // bench stands in for the watchdog
  always @(posedge aclk) watchdog_zero <= (op == 3'h4);
  rcc_top #(.LOCK_CYC(LOCK)) u_rcc_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .ext_reset_pin_n, .watchdog_zero, .halt_exec, .wait_for_interrupt, .wake_irq,
    .internal_clock_tick, .core_clock_tick, .pll_enable, .sys_reset_req, .core_halted, .irq);
  rcc_core_model u_rcc_core_model (.aclk, .aresetn, .op, .halt_exec, .wait_for_interrupt,
    .wake_irq);
  // ----
  // tasks
  // ----
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (!s_axi_awready);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (!s_axi_wready);
        s_axi_wvalid <= 1'b0;
      end
    join
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    v = s_axi_rdata;
    e = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic flg(input logic [31:0] e);
    rd(OFF_RESET_FLAGS, d, r);
    chk(d & 32'h3, e);
  endtask
  task automatic op_go(input logic [2:0] c);
    @(posedge aclk);
    op <= c;
    @(posedge aclk);
    op <= 3'h0;
  endtask
  // skips two ticks since the first period after a change may be short
  task automatic per(input logic c, input logic [31:0] e);
    int k = 0;
    repeat (2) do @(posedge aclk); while ((c ? core_clock_tick : internal_clock_tick) !== 1'b1);
    do begin
      @(posedge aclk);
      k++;
    end while ((c ? core_clock_tick : internal_clock_tick) !== 1'b1);
    chk(k, e);
  endtask
  task automatic ichk(input logic e);
    repeat (2) @(posedge aclk);
    chk(irq, e);
  endtask
  task automatic test_done();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ----
  // tests
  // ----
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(ra[i], d, r);
      chk(d, rv[i]);
    end
    chk(pll_enable, 1'b0);
    rd(8'h20, d, r);
    chk(r, RESP_SLVERR);
    wr(8'h24, 32'h1, RESP_SLVERR);
    wr(OFF_RESET_FLAGS, 32'h3, RESP_OKAY);
    flg(32'h0);
    op_go(3'h2);
    repeat (4) @(posedge aclk);
    n = 0;
    repeat (32) @(posedge aclk) n = n + core_clock_tick;
    chk(n, 32'h0);
    per(1'b0, 32'd2);
    op_go(3'h3);
    per(1'b1, 32'd2);
    wr(OFF_CORE_PRESC, 32'h7, RESP_OKAY);
    per(1'b1, 32'd16);
    wr(OFF_CORE_PRESC, 32'h0, RESP_OKAY);
    wr(OFF_CLOCK_SOURCE, 32'h1, RESP_OKAY);
    per(1'b0, 32'd32);
    wr(OFF_CLOCK_SOURCE, 32'h0, RESP_OKAY);
    wr(OFF_PLL_CONFIG, 32'h6, RESP_OKAY);
    chk(pll_enable, 1'b1);
    repeat (LOCK + 8) @(posedge aclk);
    per(1'b0, 32'd7);
    wr(OFF_PLL_CONFIG, 32'h0, RESP_OKAY);
    per(1'b0, 32'd1);
    wr(OFF_CLOCK_CONTROL, 32'h1, RESP_OKAY);
    op_go(3'h2);
    repeat (8) @(posedge aclk);
    chk(pll_enable, 1'b0);
    op_go(3'h3);
    per(1'b0, 32'd2);
    repeat (LOCK + 8) @(posedge aclk);
    per(1'b0, 32'd1);
    wr(OFF_PLL_CONFIG, 32'h7, RESP_OKAY);
    chk(pll_enable, 1'b0);
    wr(OFF_CLOCK_CONTROL, 32'h0, RESP_OKAY);
    wr(OFF_IRQ_CLEAR, 32'h7, RESP_OKAY);
    wr(OFF_IRQ_ENABLE, 32'h4, RESP_OKAY);
    ichk(1'b0);
    op_go(3'h4);
    flg(32'h2);
    ichk(1'b1);
    wr(OFF_IRQ_ENABLE, 32'h0, RESP_OKAY);
    ichk(1'b0);
    wr(OFF_IRQ_ENABLE, 32'h4, RESP_OKAY);
    ichk(1'b1);
    wr(OFF_IRQ_CLEAR, 32'h4, RESP_OKAY);
    ichk(1'b0);
    op_go(3'h1);
    flg(32'h2);
    chk(core_halted, 1'b0);
    wr(OFF_CLOCK_CONTROL, 32'h2, RESP_OKAY);
    op_go(3'h1);
    flg(32'h1);
    chk(core_halted, 1'b1);
    ext_reset_pin_n <= 1'b0;
    flg(32'h0);
    chk(core_halted, 1'b0);
    ext_reset_pin_n <= 1'b1;
    op_go(3'h4);
    flg(32'h2);
    op_go(3'h4);
    ext_reset_pin_n <= 1'b0;
    flg(32'h0);
    test_done();
  end
  // hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      test_done();
    end
  end
endmodule
bind rcc_top rcc_checker #(.LOCK_CYC(LOCK_CYC)) u_rcc_checker (.aclk, .aresetn,
  .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .ext_reset_pin_n, .watchdog_zero, .halt_exec, .wait_for_interrupt,
  .wake_irq, .internal_clock_tick, .core_clock_tick, .pll_enable, .sys_reset_req,
  .core_halted);
